// [hw/asoi_pkg.sv]
package asoi_pkg;

  // Sample clock and initialization timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned INIT_TIME_NS  = 2000;
  localparam int unsigned INIT_CYCLES   =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  INIT_LAST     = 8'(INIT_CYCLES - 1);
  localparam logic [7:0]  INIT_CNT_RST  = 8'h00;

  // Register addresses on the serial control port
  localparam logic [12:0] ADDR_POWER_MODE = 13'h008;
  localparam logic [12:0] ADDR_SERIAL_FMT = 13'h021;
  localparam logic [12:0] ADDR_USER_IO3   = 13'h102;
  localparam logic [12:0] ADDR_STATUS     = 13'h10a;

  // Values after reset and writable bits
  localparam logic [7:0]  RST_POWER_MODE  = 8'h00;
  localparam logic [7:0]  RST_SERIAL_FMT  = 8'h30;
  localparam logic [7:0]  RST_USER_IO3    = 8'h00;
  localparam logic [7:0]  MASK_POWER_MODE = 8'h23;
  localparam logic [7:0]  MASK_USER_IO3   = 8'h08;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

  // Field positions
  localparam int unsigned VCM_PD_BIT      = 3;
  localparam int unsigned FMT_ONE_LANE    = 6;
  localparam int unsigned FMT_DDR         = 5;
  localparam int unsigned FMT_BYTEWISE    = 4;
  localparam int unsigned FMT_FRAME_2X    = 2;
  localparam int unsigned FMT_12BIT       = 1;
  localparam int unsigned STAT_DONE       = 0;
  localparam int unsigned STAT_FAULT      = 1;
  localparam int unsigned STAT_RUNNING    = 2;
  localparam int unsigned STAT_DIG_RESET  = 3;

  // Power-mode field codes
  localparam logic [1:0]  PM_NORMAL       = 2'h0;
  localparam logic [1:0]  PM_FULL_PD      = 2'h1;
  localparam logic [1:0]  PM_STANDBY      = 2'h2;
  localparam logic [1:0]  PM_DIG_RESET    = 2'h3;

  // Serial control frame: 16 instruction bits then 8 data bits
  localparam logic [4:0]  SPI_LAST_INSTR  = 5'h0f;
  localparam logic [4:0]  SPI_LAST_BIT    = 5'h17;
  localparam logic [4:0]  SPI_CNT_RST     = 5'h00;
  localparam int unsigned SPI_RW_BIT      = 15;

  // Lane and frame rate multipliers of the sample rate
  localparam logic [3:0]  RATE_16_DDR     = 4'h4;
  localparam logic [3:0]  RATE_16_SDR     = 4'h8;
  localparam logic [3:0]  RATE_12_DDR     = 4'h3;
  localparam logic [3:0]  RATE_12_SDR     = 4'h6;
  localparam logic [1:0]  FRAME_1X        = 2'h1;
  localparam logic [1:0]  FRAME_2X        = 2'h2;

  typedef enum logic [3:0] {
    ST_INIT      = 4'h1,
    ST_READY     = 4'h2,
    ST_DIG_RESET = 4'h4,
    ST_FAULT     = 4'h8
  } asoi_state_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] user_io3;
    logic [7:0] serial_fmt;
    logic [7:0] power_mode;
  } asoi_snap_s;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } asoi_wr_s;

  typedef struct packed {
    logic       word_16;
    logic       frame_2x;
    logic       ddr;
    logic       one_lane;
    logic       bytewise;
    logic [3:0] lane_rate_mult;
    logic [1:0] frame_rate_mult;
  } asoi_cfg_s;

endpackage

// [hw/asoi_spi_port.sv]
`timescale 1ns/10ps
`default_nettype none

// Serial control port slave; runs only on the port's own clock.
module asoi_spi_port
  import asoi_pkg::*;
(
  input  wire logic       sclk_i,
  input  wire logic       rst_i,
  input  wire logic       port_select_one_n_i,
  input  wire logic       sdio_i,
  output logic            sdio_o,
  output logic            sdio_oe_o,
  output logic            wr_toggle_o,
  output asoi_wr_s        wr_o,
  input  wire logic       snap_toggle_i,
  input  wire asoi_snap_s snap_i
);

  typedef struct packed {
    logic [23:0] shift;
    logic [7:0]  dout;
    logic        oe;
    logic        reading;
    logic        wr_toggle;
    asoi_wr_s    wr;
    logic        snap_s1;
    logic        snap_s2;
    logic        snap_seen;
    asoi_snap_s  snap;
  } asoi_spi_s;

  asoi_spi_s  q;
  asoi_spi_s  next_q;
  logic [4:0] bit_cnt;
  logic [23:0] shifted;

  function automatic logic [7:0] reg_read(input logic [12:0] addr,
                                          input asoi_snap_s s);
    case (addr)
      ADDR_POWER_MODE: reg_read = s.power_mode;
      ADDR_SERIAL_FMT: reg_read = s.serial_fmt;
      ADDR_USER_IO3:   reg_read = s.user_io3;
      ADDR_STATUS:     reg_read = s.status;
      default:         reg_read = READ_UNMAPPED;
    endcase
  endfunction

  // The clock stops between frames, so the raised select clears the count
  always_ff @(posedge sclk_i or posedge port_select_one_n_i) begin
    if (port_select_one_n_i) begin
      bit_cnt <= SPI_CNT_RST;
    end else if (bit_cnt != SPI_LAST_BIT) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_comb begin
    next_q = q;
    shifted = {q.shift[22:0], sdio_i};
    next_q.shift = shifted;
    next_q.snap_s1 = snap_toggle_i;
    next_q.snap_s2 = q.snap_s1;
    next_q.snap_seen = q.snap_s2;
    // A quiet toggle means the copy has settled; refreshing then also
    // picks up changes whose toggles cancelled while the clock was stopped
    if ((q.snap_s2 != q.snap_seen) || (q.snap_s1 == q.snap_s2)) begin
      next_q.snap = snap_i;
    end
    if (bit_cnt == SPI_LAST_INSTR) begin
      next_q.reading = shifted[SPI_RW_BIT];
      next_q.oe = shifted[SPI_RW_BIT];
      next_q.dout = reg_read(shifted[12:0], q.snap);
    end else if (bit_cnt > SPI_LAST_INSTR) begin
      next_q.dout = {q.dout[6:0], 1'b0};
      if (bit_cnt == SPI_LAST_BIT) begin
        next_q.oe = 1'b0;
        if (!q.reading) begin
          // Address and data are held until the next write lands
          next_q.wr.addr = shifted[20:8];
          next_q.wr.data = shifted[7:0];
          next_q.wr_toggle = ~q.wr_toggle;
        end
      end
    end else begin
      next_q.oe = 1'b0;
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sdio_o      = q.dout[7];
  assign sdio_oe_o   = q.oe & ~port_select_one_n_i;
  assign wr_toggle_o = q.wr_toggle;
  assign wr_o        = q.wr;

endmodule

`default_nettype wire

// [hw/asoi_top.sv]
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1 - Bit 3 of user I/O control three powers down common-mode generator.
// RULE2 - Format register picks width, frame and lanes from fixed code set.
// RULE3 - After reset an initialization sequence runs on the sample clock.
// RULE4 - Unstable sample clock during initialization leaves device undefined.
// RULE5 - Host rewrites power mode: digital reset, then normal operation.
// RULE6 - Host also digital-resets when an external reference was unstable.
// RULE7 - Host keeps the control port idle during critical conversion.
// RULE8 - Lane bit rate 4x, 8x, 3x or 6x; 2x frame doubles frame rate.
// RULE9 - Power mode three resets datapath but not control port; zero restores.
module asoi_top
  import asoi_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       port_select_one_n_i,
  input  wire logic       sdio_i,
  output logic            sdio_o,
  output logic            sdio_oe_o,
  input  wire logic       sample_clock_stable_i,
  output asoi_cfg_s       serial_cfg_o,
  output logic            common_mode_voltage_pd_o,
  output logic            datapath_reset_o,
  output logic            datapath_clk_en_o,
  output logic            outputs_enable_o,
  output logic            init_done_o,
  output logic            init_fault_o
);

  typedef struct packed {
    asoi_state_e state;
    logic [7:0]  init_cnt;
    logic [7:0]  power_mode;
    logic [7:0]  serial_fmt;
    logic [7:0]  user_io3;
    logic        wr_s1;
    logic        wr_s2;
    logic        wr_seen;
    logic        stable_s1;
    logic        stable_s2;
    logic        snap_toggle;
    asoi_snap_s  snap;
    asoi_cfg_s   cfg;
    logic        vcm_pd;
    logic        dp_reset;
    logic        dp_clk_en;
    logic        out_en;
  } asoi_top_s;

  asoi_top_s q;
  asoi_top_s next_q;
  logic      wr_toggle;
  asoi_wr_s  wr;
  logic [1:0] pm;

  function automatic logic fmt_code_valid(input logic [7:0] code);
    fmt_code_valid = (code[7] == 1'b0) && (code[3] == 1'b0)
                     && (code[0] == 1'b0)
                     && (!code[FMT_ONE_LANE] || (code[5:2] == 4'h0));
  endfunction

  function automatic asoi_cfg_s fmt_decode(input logic [7:0] code);
    asoi_cfg_s c;
    c.word_16  = ~code[FMT_12BIT];
    c.frame_2x = code[FMT_FRAME_2X];
    c.one_lane = code[FMT_ONE_LANE];
    c.ddr      = code[FMT_DDR] | code[FMT_ONE_LANE];
    c.bytewise = code[FMT_BYTEWISE];
    // One lane carries twice the bits of a DDR lane, as much as SDR
    if (code[FMT_DDR] && !code[FMT_ONE_LANE]) begin
      c.lane_rate_mult = code[FMT_12BIT] ? RATE_12_DDR : RATE_16_DDR;
    end else begin
      c.lane_rate_mult = code[FMT_12BIT] ? RATE_12_SDR : RATE_16_SDR;
    end
    c.frame_rate_mult = code[FMT_FRAME_2X] ? FRAME_2X : FRAME_1X;
    return c;
  endfunction

  asoi_spi_port u_spi (
    .sclk_i              (spi_sclk_i),
    .rst_i               (rst_i),
    .port_select_one_n_i (port_select_one_n_i),
    .sdio_i              (sdio_i),
    .sdio_o              (sdio_o),
    .sdio_oe_o           (sdio_oe_o),
    .wr_toggle_o         (wr_toggle),
    .wr_o                (wr),
    .snap_toggle_i       (q.snap_toggle),
    .snap_i              (q.snap)
  );

  always_comb begin
    next_q = q;
    next_q.wr_s1 = wr_toggle;
    next_q.wr_s2 = q.wr_s1;
    next_q.wr_seen = q.wr_s2;
    next_q.stable_s1 = sample_clock_stable_i;
    next_q.stable_s2 = q.stable_s1;
    if (q.wr_s2 != q.wr_seen) begin
      case (wr.addr)
        ADDR_POWER_MODE: begin
          next_q.power_mode = wr.data & MASK_POWER_MODE;
        end
        ADDR_SERIAL_FMT: begin
          // Codes outside the table are ignored to keep the link sane
          if (fmt_code_valid(wr.data)) begin
            next_q.serial_fmt = wr.data; // [RULE2]
          end
        end
        ADDR_USER_IO3: begin
          next_q.user_io3 = wr.data & MASK_USER_IO3;
        end
        default: begin
        end
      endcase
    end
    pm = q.power_mode[1:0];
    case (q.state)
      ST_INIT: begin
        if (pm == PM_DIG_RESET) begin
          next_q.state = ST_DIG_RESET; // [RULE9]
        end else if (!q.stable_s2) begin
          next_q.state = ST_FAULT; // [RULE4]
        end else if (q.init_cnt == INIT_LAST) begin
          next_q.state = ST_READY; // [RULE3]
        end else begin
          next_q.init_cnt = q.init_cnt + 8'h01; // [RULE3]
        end
      end
      ST_READY: begin
        if (pm == PM_DIG_RESET) begin
          next_q.state = ST_DIG_RESET; // [RULE9]
        end
      end
      ST_DIG_RESET: begin
        // Leaving digital reset replays the whole start-up sequence
        if (pm != PM_DIG_RESET) begin
          next_q.state = ST_INIT; // [RULE5] [RULE6]
          next_q.init_cnt = INIT_CNT_RST;
        end
      end
      ST_FAULT: begin
        // Only a digital reset recovers; nothing else is trusted here
        if (pm == PM_DIG_RESET) begin
          next_q.state = ST_DIG_RESET; // [RULE4]
        end
      end
      default: begin
        next_q.state = ST_FAULT;
      end
    endcase
    pm = next_q.power_mode[1:0];
    next_q.dp_reset = (next_q.state != ST_READY)
                      || (pm == PM_FULL_PD); // [RULE9]
    next_q.dp_clk_en = (next_q.state == ST_READY)
                       && (pm == PM_NORMAL); // [RULE9]
    next_q.out_en = (next_q.state == ST_READY)
                    && (pm == PM_NORMAL); // [RULE9]
    next_q.vcm_pd = next_q.user_io3[VCM_PD_BIT]; // [RULE1]
    next_q.cfg = fmt_decode(next_q.serial_fmt); // [RULE8]
    next_q.snap.power_mode = next_q.power_mode;
    next_q.snap.serial_fmt = next_q.serial_fmt;
    next_q.snap.user_io3 = next_q.user_io3;
    next_q.snap.status = 8'h00;
    next_q.snap.status[STAT_DONE] = (next_q.state == ST_READY);
    next_q.snap.status[STAT_FAULT] = (next_q.state == ST_FAULT);
    next_q.snap.status[STAT_RUNNING] = (next_q.state == ST_INIT);
    next_q.snap.status[STAT_DIG_RESET] = (next_q.state == ST_DIG_RESET);
    // The readback copy is announced by a toggle the port side resyncs
    if (next_q.snap != q.snap) begin
      next_q.snap_toggle = ~q.snap_toggle;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.state <= ST_INIT; // [RULE3]
      q.init_cnt <= INIT_CNT_RST;
      q.power_mode <= RST_POWER_MODE;
      q.serial_fmt <= RST_SERIAL_FMT; // [RULE2]
      q.user_io3 <= RST_USER_IO3;
      q.cfg <= fmt_decode(RST_SERIAL_FMT);
      q.dp_reset <= 1'b1;
      // Keep the stable synchroniser filling so release sees the true level
      q.stable_s1 <= sample_clock_stable_i;
      q.stable_s2 <= q.stable_s1;
    end else begin
      q <= next_q;
    end
  end

  assign serial_cfg_o             = q.cfg;
  assign common_mode_voltage_pd_o = q.vcm_pd;
  assign datapath_reset_o         = q.dp_reset;
  assign datapath_clk_en_o        = q.dp_clk_en;
  assign outputs_enable_o         = q.out_en;
  assign init_done_o              = q.snap.status[STAT_DONE];
  assign init_fault_o             = q.snap.status[STAT_FAULT];

endmodule

`default_nettype wire

// [verification/asoi_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Control port master; link clock 6 ns, still between frames
module asoi_host_model (
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      sdio_o,
  input  wire logic sdio_i
);
  initial begin
    sclk_o = 1'b0;
    // Scheduled late so the port's asynchronous clear sees the edge
    sel_n_o <= 1'b1;
    sdio_o = 1'b0;
  end

  task automatic frame(input logic rw, input logic [12:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    int          i;
    w = {rw, 2'h0, a, d};
    q = 8'h00;
    #1.7;
    sel_n_o = 1'b0;
    for (i = 23; i >= 0; i--) begin
      sdio_o = w[i];
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
      if (i <= 8 && i >= 1)
        q = {q[6:0], sdio_i};
    end
    #3 sel_n_o = 1'b1;
    // Clock and data stay still until the next frame
  endtask
endmodule

`default_nettype wire

// [verification/asoi_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

module asoi_top_assertions
  import asoi_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire asoi_cfg_s serial_cfg_o,
  input  wire logic      datapath_reset_o,
  input  wire logic      datapath_clk_en_o,
  input  wire logic      outputs_enable_o,
  input  wire logic      init_done_o,
  input  wire logic      init_fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_done_fault_excl: assert property (
    !(init_done_o && init_fault_o)) else $error("done and fault both set");
  chk_clk_needs_done: assert property (
    datapath_clk_en_o |-> init_done_o) else $error("clocks on before ready");
  chk_outs_track_clk: assert property (
    outputs_enable_o == datapath_clk_en_o) else $error("outputs vs clocks");
  chk_clk_no_reset: assert property (
    datapath_clk_en_o |-> !datapath_reset_o) else $error("clock in reset");
  chk_reset_until_done: assert property (
    !init_done_o |-> datapath_reset_o) else $error("datapath free early");
  chk_init_length: assert property (
    $rose(init_done_o) |-> !$past(init_done_o, 16)) else $error("init short");
  chk_fault_exit: assert property (
    $fell(init_fault_o) |-> datapath_reset_o) else $error("fault left badly");
  chk_frame_rate: assert property (
    serial_cfg_o.frame_rate_mult ==
      (serial_cfg_o.frame_2x ? FRAME_2X : FRAME_1X))
    else $error("frame rate wrong");
  chk_lane_rate: assert property (
    serial_cfg_o.word_16 && serial_cfg_o.ddr && !serial_cfg_o.one_lane
      |-> serial_cfg_o.lane_rate_mult == RATE_16_DDR)
    else $error("lane rate wrong");

  cov_done: cover property ($rose(init_done_o));
  cov_fault: cover property ($rose(init_fault_o));
  cov_frame_2x: cover property (serial_cfg_o.frame_2x);
endmodule

bind asoi_top asoi_top_assertions i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .serial_cfg_o(serial_cfg_o),
  .datapath_reset_o(datapath_reset_o),
  .datapath_clk_en_o(datapath_clk_en_o),
  .outputs_enable_o(outputs_enable_o),
  .init_done_o(init_done_o), .init_fault_o(init_fault_o)
);

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import asoi_pkg::*;
;
  logic clk_i, rst_i, sclk, sel_n, h_sdio, d_sdio, d_oe, stable;
  logic vcm_pd, dp_rst, clk_en, out_en, done, fault;
  wire  logic sdio_w = d_oe ? d_sdio : h_sdio;
  asoi_cfg_s cfg;
  int n_mismatch = 0;
  int tests_run = 0;

  asoi_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
    .port_select_one_n_i(sel_n), .sdio_i(sdio_w), .sdio_o(d_sdio),
    .sdio_oe_o(d_oe), .sample_clock_stable_i(stable),
    .serial_cfg_o(cfg), .common_mode_voltage_pd_o(vcm_pd),
    .datapath_reset_o(dp_rst), .datapath_clk_en_o(clk_en),
    .outputs_enable_o(out_en), .init_done_o(done), .init_fault_o(fault));
  asoi_host_model i_host (.sclk_o(sclk), .sel_n_o(sel_n),
    .sdio_o(h_sdio), .sdio_i(sdio_w));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset(input logic st);
    cycles(1);
    rst_i = 1'b1;
    stable = st;
    cycles(3);
    rst_i = 1'b0;
  endtask

  // Gap keeps successive writes well apart and lets readback settle
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.frame(1'b0, a, d, q);
    cycles(8);
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_host.frame(1'b1, a, 8'h00, q);
    check(q, exp);
    cycles(2);
  endtask

  function automatic logic [3:0] exp_rate(input logic [7:0] c);
    if (c[5] && !c[6])
      return c[1] ? RATE_12_DDR : RATE_16_DDR;
    return c[1] ? RATE_12_SDR : RATE_16_SDR;
  endfunction

  task automatic t_init();
    do_reset(1'b1);
    cycles(10);
    check(done, 1'b0);
    check(dp_rst, 1'b1);
    cycles(20);
    check({done, fault, clk_en, out_en, dp_rst}, 8'h16);
    rd(ADDR_STATUS, 8'h01);
  endtask

  task automatic t_regs();
    rd(ADDR_SERIAL_FMT, 8'h30);
    rd(ADDR_USER_IO3, 8'h00);
    rd(13'h055, 8'h00);
    check(vcm_pd, 1'b0);
    wr(ADDR_USER_IO3, 8'hff);
    check(vcm_pd, 1'b1);
    rd(ADDR_USER_IO3, 8'h08);
    wr(ADDR_USER_IO3, 8'h00);
    check(vcm_pd, 1'b0);
  endtask

  task automatic t_fmt();
    logic [7:0] codes [18];
    int         i;
    codes = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h34, 8'h24, 8'h14, 8'h04,
      8'h40, 8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h26, 8'h16, 8'h06, 8'h42};
    for (i = 0; i < 18; i++) begin
      wr(ADDR_SERIAL_FMT, codes[i]);
      check(cfg.lane_rate_mult, exp_rate(codes[i]));
      check(cfg.frame_rate_mult, codes[i][2] ? 8'h02 : 8'h01);
      check({cfg.ddr, cfg.bytewise},
            {codes[i][5] | codes[i][6], codes[i][4]});
      check({cfg.word_16, cfg.frame_2x, cfg.one_lane},
            {~codes[i][1], codes[i][2], codes[i][6]});
    end
    wr(ADDR_SERIAL_FMT, 8'h41);
    rd(ADDR_SERIAL_FMT, 8'h42);
    check(cfg.lane_rate_mult, RATE_12_SDR);
  endtask

  task automatic t_fault();
    do_reset(1'b0);
    cycles(30);
    check({done, fault, dp_rst}, 8'h03);
    rd(ADDR_STATUS, 8'h02);
    stable = 1'b1;
    wr(ADDR_POWER_MODE, 8'h03); // Host restart once clock is good
    check({fault, clk_en, out_en, dp_rst}, 8'h01);
    rd(ADDR_SERIAL_FMT, 8'h30);
    wr(ADDR_POWER_MODE, 8'h00);
    cycles(30);
    check({done, out_en, dp_rst}, 8'h06);
    wr(ADDR_POWER_MODE, 8'h03); // Reference restart from ready
    check({done, dp_rst}, 8'h01);
    wr(ADDR_POWER_MODE, 8'h00);
    cycles(30);
    check(done, 1'b1);
    wr(ADDR_POWER_MODE, 8'h01); // Full power-down
    check({done, clk_en, out_en, dp_rst}, 8'h09);
    wr(ADDR_POWER_MODE, 8'h02); // Standby
    check({done, clk_en, out_en, dp_rst}, 8'h08);
    wr(ADDR_POWER_MODE, 8'h00);
    check({done, clk_en, out_en, dp_rst}, 8'h0e);
  endtask

  initial begin
    // Scheduled late so the port's asynchronous clear sees the edge
    rst_i <= 1'b1;
    stable <= 1'b1;
    t_init();
    t_regs();
    t_fmt();
    t_fault();
    conclude();
  end

  initial begin
    #300000;
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
